// file: hw/eic_defs.vh
// Constants for the external interrupt control block.
// Assumes inclusion by the Verilog-2005 design files and by the SystemVerilog bench.
`ifndef EIC_DEFS_VH
`define EIC_DEFS_VH

// ****************************************
// Register byte addresses (extra control and source select only halfword aligned)
// ****************************************
`define EIC_ADDR_W 16
`define EIC_OFS_EXTRA_CTRL 16'hf19e
`define EIC_OFS_EDGE_CFG 16'hf1c0
`define EIC_OFS_SRC_SEL 16'hf1da
`define EIC_OFS_GEN_BASE 16'hf200
`define EIC_OFS_GEN_LAST 16'hf21c
`define EIC_OFS_STATUS 16'hf220
`define EIC_OFS_MASK 16'hf224
`define EIC_OFS_WIN 16'hf228

// ****************************************
// Control register field layout
// ****************************************
`define EIC_CTRL_W 8
`define EIC_BIT_REQ 7
`define EIC_BIT_EN 6
`define EIC_PRIO_HI 5
`define EIC_PRIO_LO 2
`define EIC_GRP_HI 1
`define EIC_GRP_LO 0
`define EIC_CTRL_RST 8'h00
`define EIC_CFG_RST 16'h0000

// ****************************************
// Selector and edge encodings
// ****************************************
`define EIC_SS_PIN 2'h0
`define EIC_SS_ALT 2'h1
`define EIC_SS_OR 2'h2
`define EIC_SS_AND 2'h3
`define EIC_ES_OFF 2'h0
`define EIC_ES_RISE 2'h1
`define EIC_ES_FALL 2'h2
`define EIC_ES_ANY 2'h3

// ****************************************
// Sizes
// ****************************************
`define EIC_NCH 8
`define EIC_NSRC 9
`define EIC_IDX_W 4
`define EIC_EXTRA_IDX 4'h8

`endif

// file: hw/eic_chan.v
// One external interrupt channel: source select, sync, edge detect.
// Assumes pin and alternate inputs may be asynchronous to clk_i.
`timescale 1ns/1ps
`default_nettype none
`include "eic_defs.vh"

module eic_chan
(
    // Clock and reset
    input wire clk_i,
    input wire rst_i,
    // Inputs and configuration
    input wire pin_i,
    input wire alt_i,
    input wire [1:0] sel_i,
    input wire [1:0] edge_i,
    // Results
    output wire event_o,
    output wire wake_o,
    output wire level_o
);

    // ****************************************
    // Synchronisers and history
    // ****************************************
    reg pin_s1_ff; // First stage, pin
    reg pin_s2_ff; // Second stage, pin
    reg alt_s1_ff; // First stage, alternate
    reg alt_s2_ff; // Second stage, alternate
    reg lvl_ff; // Previous combined level
    reg nxt_lvl; // Combined level now
    reg start_ff; // Combined level captured every cycle, same as lvl_ff
    reg rise;
    reg fall;

    // Two flip-flops per external input
    always @(posedge clk_i)
    begin
        if (rst_i)
        begin
            pin_s1_ff <= 1'b0;
            pin_s2_ff <= 1'b0;
            alt_s1_ff <= 1'b0;
            alt_s2_ff <= 1'b0;
        end
        else
        begin
            pin_s1_ff <= pin_i;
            pin_s2_ff <= pin_s1_ff;
            alt_s1_ff <= alt_i;
            alt_s2_ff <= alt_s1_ff;
        end
    end

    // Source combiner
    always @*
    begin
        case (sel_i)
            `EIC_SS_PIN: nxt_lvl = pin_s2_ff; // [R7]
            `EIC_SS_ALT: nxt_lvl = alt_s2_ff; // [R7]
            `EIC_SS_OR: nxt_lvl = pin_s2_ff | alt_s2_ff; // [R7]
            `EIC_SS_AND: nxt_lvl = pin_s2_ff & alt_s2_ff; // [R7]
            default: nxt_lvl = pin_s2_ff;
        endcase
    end

    // Level history for edges; start level tracks every cycle
    always @(posedge clk_i)
    begin
        if (rst_i)
        begin
            lvl_ff <= 1'b0;
            start_ff <= 1'b0;
        end
        else
        begin
            lvl_ff <= nxt_lvl;
            start_ff <= nxt_lvl;
        end
    end

    // Edge decode per edge field
    always @*
    begin
        rise = nxt_lvl & ~lvl_ff;
        fall = ~nxt_lvl & lvl_ff;
    end

    assign event_o = (edge_i == `EIC_ES_RISE) ? rise : // [R8]
                     (edge_i == `EIC_ES_FALL) ? fall : // [R8]
                     (edge_i == `EIC_ES_ANY) ? (rise | fall) : // [R8]
                     1'b0;
    // Wake level: off ignores, high, low, any change
    assign wake_o = (edge_i == `EIC_ES_RISE) ? nxt_lvl : // [R8]
                    (edge_i == `EIC_ES_FALL) ? ~nxt_lvl : // [R8]
                    (edge_i == `EIC_ES_ANY) ? (nxt_lvl ^ start_ff) :
                    1'b0;
    assign level_o = nxt_lvl;

endmodule

`default_nettype wire

// file: hw/eic_top.v
// External interrupt controller: eight channels, nine control regs.
// Assumes a classic Wishbone master on clk_i; pins are asynchronous.
//
// Function
// R1 - Four-bit priority, all ones highest
// R2 - Two-bit group level breaks priority ties
// R3 - Enable bit gates request into arbitration
// R4 - Request flag shows pending, software writable
// R5 - Control layout req7 en6 prio5:2 grp1:0
// R6 - Extra source control uses same layout
// R7 - Selector: pin, alternate, OR, AND
// R8 - Edge field picks edge and wake level
//
// Chosen here: register access over Wishbone.
`timescale 1ns/1ps
`default_nettype none
`include "eic_defs.vh"

module eic_top
(
    // Clock and reset
    input wire clk_i,
    input wire rst_i,
    // Wishbone slave
    input wire wb_cyc_i,
    input wire wb_stb_i,
    input wire wb_we_i,
    input wire [15:0] wb_adr_i,
    input wire [3:0] wb_sel_i,
    input wire [31:0] wb_dat_i,
    output reg [31:0] wb_dat_o,
    output wire wb_ack_o,
    // External inputs
    input wire [7:0] external_irq_input_i,
    input wire [7:0] alt_src_i,
    input wire extra_src_req_i,
    // Arbitration result
    output reg req_valid_o,
    output reg [3:0] req_id_o,
    output reg [3:0] req_prio_o,
    output reg [1:0] req_grp_o,
    // Wake and interrupt
    output reg wake_o,
    output wire irq_o
);

    // ****************************************
    // Registers
    // ****************************************
    reg [7:0] ctrl_ff [0:8]; // Per-source control, 8 is extra
    reg [15:0] ext_irq_edge_config_ff; // Edge fields
    reg [15:0] ext_irq_source_select_ff; // Source fields
    reg [8:0] stat_ff; // Sticky event status
    reg [8:0] mask_ff; // Interrupt mask
    reg ack_ff; // Bus acknowledge
    reg extra_s1_ff; // Extra source sync stage 1
    reg extra_s2_ff; // Extra source sync stage 2
    reg extra_d_ff; // Extra source history
    wire [8:0] evt; // Event pulses per source
    wire [7:0] wake; // Wake levels per channel
    wire [7:0] lvl; // Combined levels (unused beyond debug)
    wire acc; // Bus access this cycle
    wire wr; // Write strobe
    wire [3:0] gidx; // Control register index
    wire gsel; // Address hits a control register

    // ****************************************
    // Bus decode
    // ****************************************
    assign acc = wb_cyc_i & wb_stb_i & ~ack_ff;
    assign wr = acc & wb_we_i & wb_sel_i[0];
    assign gidx = wb_adr_i[5:2];
    assign gsel = (wb_adr_i >= `EIC_OFS_GEN_BASE) &&
                  (wb_adr_i <= `EIC_OFS_GEN_LAST) &&
                  (wb_adr_i[1:0] == 2'h0);
    assign wb_ack_o = ack_ff;

    // Single cycle acknowledge, dropped after one clock
    always @(posedge clk_i)
    begin
        if (rst_i)
            ack_ff <= 1'b0;
        else
            ack_ff <= acc;
    end

    // ****************************************
    // Channels
    // ****************************************
    genvar g;
    generate
        for (g = 0; g < `EIC_NCH; g = g + 1)
        begin : gen_ch
            eic_chan u_ch
            (
                .clk_i(clk_i),
                .rst_i(rst_i),
                .pin_i(external_irq_input_i[g]),
                .alt_i(alt_src_i[g]),
                .sel_i(ext_irq_source_select_ff[2*g+1:2*g]),
                .edge_i(ext_irq_edge_config_ff[2*g+1:2*g]),
                .event_o(evt[g]),
                .wake_o(wake[g]),
                .level_o(lvl[g])
            );
        end
    endgenerate

    // Extra source: synchronised, rising edge is its request
    always @(posedge clk_i)
    begin
        if (rst_i)
        begin
            extra_s1_ff <= 1'b0;
            extra_s2_ff <= 1'b0;
            extra_d_ff <= 1'b0;
        end
        else
        begin
            extra_s1_ff <= extra_src_req_i;
            extra_s2_ff <= extra_s1_ff;
            extra_d_ff <= extra_s2_ff;
        end
    end
    assign evt[8] = extra_s2_ff & ~extra_d_ff;

    // ****************************************
    // Control registers
    // ****************************************
    // Request flag set by event wins over software write
    integer i;
    always @(posedge clk_i)
    begin
        if (rst_i)
        begin
            for (i = 0; i < `EIC_NSRC; i = i + 1)
                ctrl_ff[i] <= `EIC_CTRL_RST; // [R5]
        end
        else
        begin
            for (i = 0; i < `EIC_NSRC; i = i + 1)
            begin
                if (wr && gsel && gidx == i[3:0])
                    ctrl_ff[i] <= wb_dat_i[7:0]; // [R4] [R5] [R6]
                else if (wr && i == 8 &&
                         wb_adr_i == `EIC_OFS_EXTRA_CTRL)
                    ctrl_ff[i] <= wb_dat_i[7:0]; // [R6]
                if (evt[i])
                    ctrl_ff[i][`EIC_BIT_REQ] <= 1'b1; // [R4]
            end
        end
    end

    // Configuration and interrupt registers
    always @(posedge clk_i)
    begin
        if (rst_i)
        begin
            ext_irq_edge_config_ff <= `EIC_CFG_RST;
            ext_irq_source_select_ff <= `EIC_CFG_RST;
            stat_ff <= 9'h000;
            mask_ff <= 9'h000;
        end
        else
        begin
            if (wr && wb_adr_i == `EIC_OFS_EDGE_CFG && wb_sel_i[1])
                ext_irq_edge_config_ff <= wb_dat_i[15:0]; // [R8]
            if (wr && wb_adr_i == `EIC_OFS_SRC_SEL && wb_sel_i[1])
                ext_irq_source_select_ff <= wb_dat_i[15:0]; // [R7]
            if (wr && wb_adr_i == `EIC_OFS_MASK && wb_sel_i[1])
                mask_ff <= wb_dat_i[8:0];
            // Write one to clear; new events win
            if (wr && wb_adr_i == `EIC_OFS_STATUS && wb_sel_i[1])
                stat_ff <= (stat_ff & ~wb_dat_i[8:0]) | evt;
            else
                stat_ff <= stat_ff | evt;
        end
    end

    assign irq_o = |(stat_ff & mask_ff);

    // ****************************************
    // Read mux
    // ****************************************
    always @(posedge clk_i)
    begin
        if (rst_i)
            wb_dat_o <= 32'h0000_0000;
        else if (acc && !wb_we_i)
        begin
            if (gsel && gidx < `EIC_NSRC)
                wb_dat_o <= {24'h000000, ctrl_ff[gidx]};
            else if (wb_adr_i == `EIC_OFS_EXTRA_CTRL)
                wb_dat_o <= {24'h000000, ctrl_ff[8]};
            else if (wb_adr_i == `EIC_OFS_EDGE_CFG)
                wb_dat_o <= {16'h0000, ext_irq_edge_config_ff};
            else if (wb_adr_i == `EIC_OFS_SRC_SEL)
                wb_dat_o <= {16'h0000, ext_irq_source_select_ff};
            else if (wb_adr_i == `EIC_OFS_STATUS)
                wb_dat_o <= {23'h000000, stat_ff};
            else if (wb_adr_i == `EIC_OFS_MASK)
                wb_dat_o <= {23'h000000, mask_ff};
            else if (wb_adr_i == `EIC_OFS_WIN)
                wb_dat_o <= {28'h0000000, req_id_o};
            else
                wb_dat_o <= 32'h0000_0000;
        end
    end

    // ****************************************
    // Arbitration
    // ****************************************
    reg found;
    reg [3:0] best_id;
    reg [5:0] best_key;
    reg [5:0] key;
    integer k;
    // Highest priority then group wins; enable gates entry
    always @*
    begin
        found = 1'b0;
        best_id = 4'h0;
        best_key = 6'h00;
        key = 6'h00;
        for (k = 0; k < `EIC_NSRC; k = k + 1)
        begin
            key = ctrl_ff[k][`EIC_PRIO_HI:`EIC_GRP_LO]; // [R1] [R2]
            if (ctrl_ff[k][`EIC_BIT_REQ] &&
                ctrl_ff[k][`EIC_BIT_EN] && // [R3]
                (!found || key > best_key)) // [R1] [R2]
            begin
                found = 1'b1;
                best_key = key;
                best_id = k[3:0];
            end
        end
    end

    // Registered arbitration result
    always @(posedge clk_i)
    begin
        if (rst_i)
        begin
            req_valid_o <= 1'b0;
            req_id_o <= 4'h0;
            req_prio_o <= 4'h0;
            req_grp_o <= 2'h0;
            wake_o <= 1'b0;
        end
        else
        begin
            req_valid_o <= found;
            req_id_o <= best_id;
            req_prio_o <= best_key[5:2];
            req_grp_o <= best_key[1:0];
            wake_o <= |wake; // [R8]
        end
    end

endmodule

`default_nettype wire

// file: bench/eic_props.sv
// Port checker for the external interrupt controller.
// Assumes a bind onto eic_top and one clock domain.
`timescale 1ns/1ps
`default_nettype none
module eic_props
(
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Bus
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [15:0] wb_adr_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic wb_ack_o,
    // Results
    input wire logic req_valid_o,
    input wire logic [3:0] req_id_o,
    input wire logic wake_o,
    input wire logic irq_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    wire logic rq = wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_we_i;
    property p_ack;
        wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o;
    endproperty
    a_ack: assert property (p_ack) else $error("no ack");
    property p_pulse;
        wb_ack_o |=> !wb_ack_o;
    endproperty
    a_pulse: assert property (p_pulse) else $error("long ack");
    property p_rst;
        $fell(rst_i) |-> !wb_ack_o && !req_valid_o && !irq_o && !wake_o;
    endproperty
    a_rst: assert property (p_rst) else $error("reset out");
    property p_unmap;
        rq && wb_adr_i == 16'hf230 |=> wb_dat_o == 32'h0;
    endproperty
    a_unmap: assert property (p_unmap) else $error("unmapped");
    property p_ctrl;
        rq && wb_adr_i >= 16'hf200 && wb_adr_i <= 16'hf21c
            |=> wb_dat_o[31:8] == 24'h0;
    endproperty
    a_ctrl: assert property (p_ctrl) else $error("ctrl width");
    property p_extra;
        rq && wb_adr_i == 16'hf19e |=> wb_dat_o[31:8] == 24'h0;
    endproperty
    a_extra: assert property (p_extra) else $error("extra width");
    property p_cfg;
        rq && (wb_adr_i == 16'hf1c0 || wb_adr_i == 16'hf1da)
            |=> wb_dat_o[31:16] == 16'h0;
    endproperty
    a_cfg: assert property (p_cfg) else $error("cfg width");
    property p_id;
        req_valid_o |-> req_id_o <= 4'h8;
    endproperty
    a_id: assert property (p_id) else $error("bad id");
    property p_hold;
        $fell(req_valid_o) |-> $past(wb_we_i, 1) || $past(wb_we_i, 2)
            || $past(wb_we_i, 3);
    endproperty
    a_hold: assert property (p_hold) else $error("lost req");
endmodule
bind eic_top eic_props u_props (.*);
`default_nettype wire

// file: bench/eic_src_model.sv
// Pins and alternate sources seen by the controller.
// Assumes the bench calls drive from one process.
`timescale 1ns/1ps
`default_nettype none
module eic_src_model
(
    // Clock
    input wire logic clk_i,
    // Source levels
    output var logic [7:0] pin_o,
    output var logic [7:0] alt_o,
    output var logic extra_o
);
    initial
    begin
        pin_o = 8'h00;
        alt_o = 8'h00;
        extra_o = 1'b0;
    end
    // Change levels just after an edge
    task drive(input logic [7:0] p, input logic [7:0] a, input logic x);
        @(posedge clk_i);
        pin_o <= p;
        alt_o <= a;
        extra_o <= x;
    endtask
endmodule
`default_nettype wire

// file: bench/test_external_interrupt_control.sv
// Bench for the external interrupt controller.
// Assumes eic_top, its checker and the source model.
`timescale 1ns/1ps
`default_nettype none
`include "eic_defs.vh"
module test_external_interrupt_control;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic wb_cyc_i = 1'b0;
    logic wb_stb_i = 1'b0;
    logic wb_we_i = 1'b0;
    logic [15:0] wb_adr_i = 16'h0;
    logic [31:0] wb_dat_i = 32'h0;
    wire logic [31:0] wb_dat_o;
    wire logic wb_ack_o, req_valid_o, wake_o, irq_o, x_w;
    wire logic [3:0] req_id_o, req_prio_o;
    wire logic [1:0] req_grp_o;
    wire logic [7:0] pin_w, alt_w;
    logic p, a;
    int n_fail = 0;
    int comparisons = 0;
    int k, m;
    always #12.5 clk_i = ~clk_i;
    eic_top DUT (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
        .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
        .wb_sel_i(4'hf), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
        .wb_ack_o(wb_ack_o), .external_irq_input_i(pin_w),
        .alt_src_i(alt_w), .extra_src_req_i(x_w),
        .req_valid_o(req_valid_o), .req_id_o(req_id_o),
        .req_prio_o(req_prio_o), .req_grp_o(req_grp_o),
        .wake_o(wake_o), .irq_o(irq_o));
    eic_src_model src (.clk_i(clk_i), .pin_o(pin_w), .alt_o(alt_w),
        .extra_o(x_w));
    task stop_test;
        $display("fails %0d comparisons %0d", n_fail, comparisons);
        if (n_fail == 0 && comparisons > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    task chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp)
        begin
            n_fail++;
            $display("wrong value %0t got %h want %h", $time, got, exp);
        end
    endtask
    // One classic cycle, ends settled after the release
    task acc(input logic we, input logic [15:0] ad, input logic [31:0] d,
        output logic [31:0] q);
        int n;
        @(posedge clk_i);
        {wb_cyc_i, wb_stb_i, wb_we_i} <= {2'b11, we};
        wb_adr_i <= ad;
        wb_dat_i <= d;
        n = 0;
        do
        begin
            @(posedge clk_i);
            n++;
        end
        while (wb_ack_o !== 1'b1 && n < 50);
        if (n >= 50)
            chk(32'h1, 32'h0);
        q = wb_dat_o;
        {wb_cyc_i, wb_stb_i, wb_we_i} <= 3'b000;
        @(negedge clk_i);
    endtask
    task wr(input logic [15:0] ad, input logic [31:0] d);
        logic [31:0] q;
        acc(1'b1, ad, d, q);
    endtask
    task rd(input logic [15:0] ad, input logic [31:0] e);
        logic [31:0] q;
        acc(1'b0, ad, 32'h0, q);
        chk(q, e);
    endtask
    task w(input int n);
        repeat (n) @(negedge clk_i);
    endtask
    function automatic logic [15:0] ga(input int n);
        return `EIC_OFS_GEN_BASE + 16'(4 * n);
    endfunction
    // Watchdog
    initial
    begin
        repeat (40000) @(posedge clk_i);
        n_fail++;
        stop_test();
    end
    initial
    begin
        repeat (12) @(posedge clk_i);
        rst_i <= 1'b0;
        for (k = 0; k < 8; k++) rd(ga(k), 0);
        rd(`EIC_OFS_EXTRA_CTRL, 0);
        rd(`EIC_OFS_EDGE_CFG, 0);
        rd(`EIC_OFS_SRC_SEL, 0);
        wr(16'hf230, 32'hffffffff);
        rd(16'hf230, 0);
        wr(ga(5), 32'hffffff3c);
        rd(ga(5), 32'h3c);
        wr(`EIC_OFS_EXTRA_CTRL, 32'h1bd);
        rd(`EIC_OFS_EXTRA_CTRL, 32'hbd);
        w(4);
        chk(req_valid_o, 0);
        wr(`EIC_OFS_EXTRA_CTRL, 0);
        wr(ga(5), 0);
        // Selector modes on channel 0, rising edge
        wr(`EIC_OFS_EDGE_CFG, 1);
        for (m = 0; m < 4; m++)
            for (k = 0; k < 3; k++)
            begin
                p = (k != 1);
                a = (k != 0);
                wr(`EIC_OFS_SRC_SEL, m);
                src.drive(0, 0, 0);
                w(8);
                wr(ga(0), 0);
                src.drive({7'h0, p}, {7'h0, a}, 0);
                w(10);
                rd(ga(0), {(m == 0) ? p : (m == 1) ? a
                    : (m == 2) ? (p | a) : (p & a), 7'h0});
            end
        // Edge and wake modes from the pin
        wr(`EIC_OFS_SRC_SEL, 0);
        for (m = 0; m < 4; m++)
        begin
            wr(`EIC_OFS_EDGE_CFG, m);
            src.drive(0, 0, 0);
            w(8);
            wr(ga(0), 0);
            src.drive(1, 0, 0);
            w(10);
            rd(ga(0), {m[0], 7'h0});
            chk(wake_o, m == 1);
            wr(ga(0), 0);
            src.drive(0, 0, 0);
            w(10);
            rd(ga(0), {m[1], 7'h0});
            chk(wake_o, m == 2);
        end
        // Arbitration by level, group and enable
        wr(ga(0), 0);
        wr(ga(1), 32'hd5);
        wr(ga(2), 32'hd7);
        wr(ga(3), 32'hd3);
        wr(ga(4), 32'hbf);
        w(4);
        chk({req_valid_o, req_id_o, req_prio_o, req_grp_o}, 11'h497);
        wr(ga(2), 0);
        w(4);
        chk({req_valid_o, req_id_o, req_prio_o, req_grp_o}, 11'h455);
        wr(ga(1), 0);
        w(4);
        chk({req_valid_o, req_id_o, req_prio_o, req_grp_o}, 11'h4d3);
        wr(`EIC_OFS_EXTRA_CTRL, 32'h7c);
        src.drive(0, 0, 1);
        w(10);
        chk({req_valid_o, req_id_o, req_prio_o, req_grp_o}, 11'h63c);
        rd(`EIC_OFS_EXTRA_CTRL, 32'hfc);
        wr(`EIC_OFS_EXTRA_CTRL, 0);
        wr(ga(3), 0);
        w(4);
        chk(req_valid_o, 0);
        // Status, mask and interrupt line
        wr(`EIC_OFS_STATUS, 32'h1ff);
        wr(`EIC_OFS_MASK, 1);
        chk(irq_o, 0);
        src.drive(1, 0, 0);
        w(10);
        chk(irq_o, 1);
        rd(`EIC_OFS_MASK, 1);
        wr(`EIC_OFS_MASK, 0);
        chk(irq_o, 0);
        wr(`EIC_OFS_MASK, 1);
        chk(irq_o, 1);
        wr(`EIC_OFS_STATUS, 1);
        chk(irq_o, 0);
        stop_test();
    end
endmodule
`default_nettype wire
